// File: design/clk_ctrl.sv
// Clock source selection, tuning, wake-up gate and CPU clock divider.
//
// How it works
// RQ1: A six-bit tuning field, writable by software, adjusts the RC oscillator.
// RQ2: Reset loads the tuning field with the factory value for nominal frequency.
// RQ3: Software may rewrite the tuning field at run time to retune the oscillator.
// RQ4: With the doubler configured, the RC source ticks on both edges.
// RQ5: Software sets the low-power bit only when the CPU clock is slow.
// RQ6: Every reset clears the clock low-power bit.
// RQ7: Tuning bit 7 picks the RC oscillator over the configured source; the code takes this select from bit 6 of trim_wr_t (rc_sel).
// RQ8: The watchdog oscillator is a selectable low-power clock source.
// RQ9: An external source drives the clock pin from zero up to 18 MHz.
// RQ10: Above 12 MHz the system must enable the reset input function.
// RQ11: A wake-up timer holds the CPU clock until the new source settles.
// RQ12: The divider divides the oscillator clock by up to 510.
// RQ13: Divider changes take effect at any time without stalling execution.
// RQ14: When the external clock is unused its pin is a plain input.
// RQ15: Only power-on reset loads the tuning register; other resets keep it.
// RQ16: The peripheral clock is the CPU clock divided by two.
// RQ17: Setting N divides by 2N; N of zero passes the clock straight.
// RQ18: Source and ratio changes land on tick boundaries, so no short phases.
`timescale 1ns/100ps
module clk_ctrl
    import clk_ctrl_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic SYS_RESET_I,
    input wire user_cfg_t USER_CFG_I,
    input wire logic RC_OSC_I,
    input wire logic WDOG_OSC_I,
    input wire logic EXT_CLK_PIN_I,
    input wire logic TRIM_WE_I,
    input wire trim_wr_t TRIM_WDATA_I,
    input wire logic DIV_WE_I,
    input wire logic [7:0] DIV_WDATA_I,
    input wire logic CLOCK_LOW_POWER_BIT_WE_I,
    input wire logic CLOCK_LOW_POWER_BIT_WDATA_I,
    output logic [5:0] TRIM_O,
    output logic RC_SEL_O,
    output logic [7:0] DIV_O,
    output logic CLOCK_LOW_POWER_BIT_O,
    output logic OSC_EN_O,
    output logic CPU_EN_O,
    output logic PCLK_EN_O,
    output logic CPU_RUN_O,
    output clk_src_t ACTIVE_SRC_O,
    output logic PIN_GPIO_O
);

    // ------------------------------------------------------------------
    // Oscillator inputs
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0] osc_raw;
    logic [NUM_SRC-1:0] osc_lvl;
    logic [NUM_SRC-1:0] osc_rise;
    logic [NUM_SRC-1:0] osc_fall;
    logic [NUM_SRC-1:0] src_tick;

    assign osc_raw = {EXT_CLK_PIN_I, WDOG_OSC_I, RC_OSC_I};

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            osc_edge u_edge (
                .clk_i(MCLK_I),
                .rst_n_i(RESET_N_I),
                .osc_i(osc_raw[g]),
                .level_o(osc_lvl[g]),
                .rise_o(osc_rise[g]),
                .fall_o(osc_fall[g])
            );
            if (g == int'(SRC_RC)) begin : g_dbl
                // RQ4 doubler on both edges
                assign src_tick[g] = osc_rise[g]
                    | (osc_fall[g] & USER_CFG_I.doubler);
            end else begin : g_plain
                assign src_tick[g] = osc_rise[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Software-visible control bits
    // ------------------------------------------------------------------
    logic [5:0] trim_q;
    logic [5:0] trim_d;
    logic rc_sel_q;
    logic rc_sel_d;
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic clock_low_power_bit_q;
    logic clock_low_power_bit_d;

    always_comb begin
        trim_d = trim_q;
        rc_sel_d = rc_sel_q;
        div_d = div_q;
        clock_low_power_bit_d = clock_low_power_bit_q;
        // RQ1 tuning field write
        // RQ3 run-time retune
        if (TRIM_WE_I) begin
            trim_d = TRIM_WDATA_I.trim;
            rc_sel_d = TRIM_WDATA_I.rc_sel;
        end
        // RQ13 divider written in any cycle without a system reset
        if (DIV_WE_I) begin
            div_d = DIV_WDATA_I;
        end
        if (CLOCK_LOW_POWER_BIT_WE_I) begin
            clock_low_power_bit_d = CLOCK_LOW_POWER_BIT_WDATA_I;
        end
        // RQ6 any reset clears low-power
        // The system reset leaves the tuning bits alone on purpose.
        if (SYS_RESET_I) begin
            div_d = DIV_RESET;
            clock_low_power_bit_d = CLOCK_LOW_POWER_BIT_RESET;
        end
    end

    // RQ2 factory value on power-on
    // RQ15 only power-on loads trim
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            trim_q <= TRIM_FACTORY;
            rc_sel_q <= RC_SEL_RESET;
            div_q <= DIV_RESET;
            clock_low_power_bit_q <= CLOCK_LOW_POWER_BIT_RESET;
        end else begin
            trim_q <= trim_d;
            rc_sel_q <= rc_sel_d;
            div_q <= div_d;
            clock_low_power_bit_q <= clock_low_power_bit_d;
        end
    end

    // ------------------------------------------------------------------
    // Source selection and wake-up gate
    // ------------------------------------------------------------------
    typedef enum logic {
        ST_WAKE,
        ST_RUN
    } wake_state_t;

    wake_state_t state_q;
    wake_state_t state_d;
    clk_src_t want_src;
    clk_src_t active_q;
    clk_src_t active_d;
    logic [11:0] wake_cnt_q;
    logic [11:0] wake_cnt_d;
    logic [11:0] wake_lim;
    logic want_tick;
    logic act_tick;

    always_comb begin
        // RQ7 RC select overrides
        // RQ8 watchdog oscillator selectable
        want_src = rc_sel_q ? SRC_RC : USER_CFG_I.src;
        if (want_src == SRC_EXT) begin
            want_tick = src_tick[SRC_EXT];
        end else if (want_src == SRC_WDOG) begin
            want_tick = src_tick[SRC_WDOG];
        end else begin
            want_tick = src_tick[SRC_RC];
        end
        if (active_q == SRC_EXT) begin
            act_tick = src_tick[SRC_EXT];
        end else if (active_q == SRC_WDOG) begin
            act_tick = src_tick[SRC_WDOG];
        end else begin
            act_tick = src_tick[SRC_RC];
        end
        case (want_src)
            SRC_WDOG: wake_lim = WAKE_WDOG_TICKS;
            SRC_EXT: wake_lim = WAKE_EXT_TICKS;
            default: wake_lim = WAKE_RC_TICKS;
        endcase
    end

    logic [8:0] div_cnt_q;
    logic [8:0] div_cnt_d;
    logic [8:0] ratio_q;
    logic [8:0] ratio_d;
    logic boundary;
    logic cpu_tick;

    always_comb begin
        state_d = state_q;
        active_d = active_q;
        wake_cnt_d = wake_cnt_q;
        case (state_q)
            ST_WAKE: begin
                // RQ11 hold until settled
                if (want_src != active_q) begin
                    active_d = want_src;
                    wake_cnt_d = '0;
                end else if (want_tick) begin
                    if (wake_cnt_q >= wake_lim - 12'h001) begin
                        state_d = ST_RUN;
                        wake_cnt_d = '0;
                    end else begin
                        wake_cnt_d = wake_cnt_q + 12'h001;
                    end
                end
            end
            ST_RUN: begin
                // RQ18 switch only at boundary
                if (want_src != active_q && boundary) begin
                    state_d = ST_WAKE;
                    active_d = want_src;
                    wake_cnt_d = '0;
                end
            end
            default: begin
                state_d = ST_WAKE;
            end
        endcase
        if (SYS_RESET_I) begin
            state_d = ST_WAKE;
            wake_cnt_d = '0;
        end
    end

    // ------------------------------------------------------------------
    // CPU clock divider
    // ------------------------------------------------------------------
    logic pclk_ph_q;
    logic pclk_ph_d;

    always_comb begin
        div_cnt_d = div_cnt_q;
        ratio_d = ratio_q;
        pclk_ph_d = pclk_ph_q;
        cpu_tick = 1'b0;
        // A ratio of 2N needs 2N ticks; zero means one tick per cycle.
        boundary = (div_cnt_q == 9'h000);
        if (state_q == ST_RUN && act_tick) begin
            // RQ12 divide by up to 510
            // RQ17 N gives 2N, zero bypass
            if (ratio_q == 9'h000 || div_cnt_q >= ratio_q - 9'h001) begin
                cpu_tick = 1'b1;
                div_cnt_d = '0;
                // RQ13 new ratio at boundary
                ratio_d = {div_q, 1'b0};
                // RQ16 peripheral clock halves
                pclk_ph_d = ~pclk_ph_q;
            end else begin
                div_cnt_d = div_cnt_q + 9'h001;
            end
        end else if (state_q == ST_WAKE) begin
            div_cnt_d = '0;
            ratio_d = {div_q, 1'b0};
            // The first CPU pulse of each run comes without a peripheral pulse.
            pclk_ph_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q <= ST_WAKE;
            active_q <= SRC_RC;
            wake_cnt_q <= '0;
            div_cnt_q <= '0;
            ratio_q <= '0;
            pclk_ph_q <= 1'b0;
        end else begin
            state_q <= state_d;
            active_q <= active_d;
            wake_cnt_q <= wake_cnt_d;
            div_cnt_q <= div_cnt_d;
            ratio_q <= ratio_d;
            pclk_ph_q <= pclk_ph_d;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    logic osc_en_q;
    logic cpu_en_q;
    logic pclk_en_q;
    logic gpio_q;
    logic gpio_d;
    logic run_q;
    logic run_d;

    always_comb begin
        // RQ14 pin is ordinary input
        gpio_d = (active_q == SRC_EXT) ? 1'b0 : osc_lvl[SRC_EXT];
        // RQ11 no pulse leaves run
        // A tick that meets the step into wake-up is dropped, so no pulse
        // escapes while the run flag already reads low.
        run_d = (state_d == ST_RUN);
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            osc_en_q <= 1'b0;
            cpu_en_q <= 1'b0;
            pclk_en_q <= 1'b0;
            gpio_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            osc_en_q <= (state_q == ST_RUN) & act_tick & run_d;
            cpu_en_q <= cpu_tick & run_d;
            pclk_en_q <= cpu_tick & pclk_ph_q & run_d;
            gpio_q <= gpio_d;
            run_q <= run_d;
        end
    end

    assign TRIM_O = trim_q;
    assign RC_SEL_O = rc_sel_q;
    assign DIV_O = div_q;
    assign CLOCK_LOW_POWER_BIT_O = clock_low_power_bit_q;
    assign OSC_EN_O = osc_en_q;
    assign CPU_EN_O = cpu_en_q;
    assign PCLK_EN_O = pclk_en_q;
    assign CPU_RUN_O = run_q;
    assign ACTIVE_SRC_O = active_q;
    assign PIN_GPIO_O = gpio_q;

endmodule : clk_ctrl

// File: design/clk_ctrl_pkg.sv
// Shared constants and types for the system clock source and divider.
package clk_ctrl_pkg;

    // ------------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_RC,
        SRC_WDOG,
        SRC_EXT
    } clk_src_t;

    localparam int NUM_SRC = 3;

    // ------------------------------------------------------------------
    // Tuning register layout and reset value
    // ------------------------------------------------------------------
    localparam int TRIM_W = 6;
    localparam int RC_SEL_BIT = 7;
    localparam logic [5:0] TRIM_FACTORY = 6'h20;
    localparam logic RC_SEL_RESET = 1'b0;

    // ------------------------------------------------------------------
    // Divider and low-power reset values
    // ------------------------------------------------------------------
    localparam int DIV_W = 8;
    localparam int DIV_CNT_W = 9;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic CLOCK_LOW_POWER_BIT_RESET = 1'b0;

    // ------------------------------------------------------------------
    // Wake-up delays, counted in ticks of the incoming source
    // ------------------------------------------------------------------
    localparam int WAKE_W = 12;
    localparam logic [11:0] WAKE_RC_TICKS = 12'h100;
    localparam logic [11:0] WAKE_WDOG_TICKS = 12'h020;
    localparam logic [11:0] WAKE_EXT_TICKS = 12'h400;

    // ------------------------------------------------------------------
    // User configuration byte fields used by this block
    // ------------------------------------------------------------------
    typedef struct packed {
        clk_src_t src;
        logic doubler;
    } user_cfg_t;

    // Software writes to the tuning register.
    typedef struct packed {
        logic rc_sel;
        logic [5:0] trim;
    } trim_wr_t;

endpackage : clk_ctrl_pkg

// File: design/osc_edge.sv
// Two-stage synchroniser with edge pulses for one oscillator input.
`timescale 1ns/100ps
module osc_edge (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic osc_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic prev_d;

    always_comb begin
        meta_d = osc_i;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
    assign fall_o = ~sync_q & prev_q;

endmodule : osc_edge

// File: sim/ext_clk_src.sv
// Free-running clock source model for oscillator and clock pin inputs.
`timescale 1ns/100ps
module ext_clk_src #(
    parameter int HALF_NS = 400,
    parameter int OFS_NS = 37
) (
    input wire logic en_i,
    input wire logic idle_i,
    output logic clk_o
);
    logic ph = 1'b0;

    initial begin
        #(OFS_NS);
        forever #(HALF_NS) ph = ~ph;
    end

    // rate within range
    // A disabled source holds the pin level, so no stray ticks appear.
    assign clk_o = en_i ? ph : idle_i;
endmodule : ext_clk_src

// File: sim/clk_ctrl_props.sv
// Concurrent checks on the ports of the clock control block.
`timescale 1ns/100ps
module clk_ctrl_props
    import clk_ctrl_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic SYS_RESET_I,
    input wire logic TRIM_WE_I,
    input wire trim_wr_t TRIM_WDATA_I,
    input wire logic DIV_WE_I,
    input wire logic [7:0] DIV_WDATA_I,
    input wire logic [5:0] TRIM_O,
    input wire logic RC_SEL_O,
    input wire logic [7:0] DIV_O,
    input wire logic CLOCK_LOW_POWER_BIT_O,
    input wire logic OSC_EN_O,
    input wire logic CPU_EN_O,
    input wire logic PCLK_EN_O,
    input wire logic CPU_RUN_O,
    input wire clk_src_t ACTIVE_SRC_O,
    input wire logic PIN_GPIO_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    a_reset_trim: assert property (
        $rose(RESET_N_I) |-> TRIM_O == TRIM_FACTORY && DIV_O == DIV_RESET)
        else $error("bad value after power-on reset");
    a_trim_write: assert property (
        TRIM_WE_I |=> {RC_SEL_O, TRIM_O} == $past(TRIM_WDATA_I))
        else $error("tuning write lost");
    a_div_write: assert property (
        DIV_WE_I && !SYS_RESET_I |=> DIV_O == $past(DIV_WDATA_I))
        else $error("divider write lost");
    a_sys_clear: assert property (
        SYS_RESET_I |=> DIV_O == 8'h00 && !CLOCK_LOW_POWER_BIT_O)
        else $error("reset left divider or low-power bit");
    a_trim_keep: assert property (
        SYS_RESET_I && !TRIM_WE_I |=> $stable(TRIM_O) && $stable(RC_SEL_O))
        else $error("reset changed tuning");
    a_wake_hold: assert property (
        !CPU_RUN_O |-> !CPU_EN_O && !OSC_EN_O)
        else $error("clock pulse during wake-up");
    a_pclk_half: assert property (
        PCLK_EN_O |-> CPU_EN_O ##1 !PCLK_EN_O [*3])
        else $error("peripheral pulse spacing wrong");
    a_cpu_space: assert property (
        CPU_EN_O |=> !CPU_EN_O)
        else $error("short CPU clock phase");
    a_gpio_ext: assert property (
        ACTIVE_SRC_O == SRC_EXT [*3] |-> !PIN_GPIO_O)
        else $error("pin level shown while used as clock");

    c_ext_run: cover property (ACTIVE_SRC_O == SRC_EXT && CPU_EN_O);
    c_slow: cover property (DIV_O == 8'hFF && CPU_EN_O);
    c_refused: cover property (SYS_RESET_I && DIV_WE_I);
endmodule : clk_ctrl_props

bind clk_ctrl clk_ctrl_props i_props (.MCLK_I(MCLK_I),
    .RESET_N_I(RESET_N_I), .SYS_RESET_I(SYS_RESET_I),
    .TRIM_WE_I(TRIM_WE_I), .TRIM_WDATA_I(TRIM_WDATA_I),
    .DIV_WE_I(DIV_WE_I), .DIV_WDATA_I(DIV_WDATA_I), .TRIM_O(TRIM_O),
    .RC_SEL_O(RC_SEL_O), .DIV_O(DIV_O), .CLOCK_LOW_POWER_BIT_O(CLOCK_LOW_POWER_BIT_O),
    .OSC_EN_O(OSC_EN_O), .CPU_EN_O(CPU_EN_O), .PCLK_EN_O(PCLK_EN_O),
    .CPU_RUN_O(CPU_RUN_O), .ACTIVE_SRC_O(ACTIVE_SRC_O),
    .PIN_GPIO_O(PIN_GPIO_O));

// File: sim/tb.sv
// Self-checking testbench for the clock source and divider block.
`timescale 1ns/100ps
module tb;
    import clk_ctrl_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sys_rst = 1'b0;
    user_cfg_t cfg = '{SRC_RC, 1'b0};
    logic trim_we = 1'b0, div_we = 1'b0, lp_we = 1'b0;
    logic [7:0] wd = 8'h00;
    logic ext_en = 1'b0, ext_idle = 1'b0, osc_on = 1'b1;
    logic rc_osc, wd_osc, ext_pin, rc_sel, lp, osc_en, cpu_en, pclk_en;
    logic run, gpio;
    logic [5:0] trim, t;
    logic [7:0] div;
    logic [7:0] nl[5] = '{8'h00, 8'h01, 8'h03, 8'hFF, 8'h00};
    clk_src_t src;
    int err_count = 0, checks = 0, cyc = 0, lc = 0, cg = 0;
    int pk = 0, og = 0, lo = 0;
    logic [31:0] val_q[$];
    logic [3:0] sel_q[$];

    always #50 mclk = ~mclk;

    clk_ctrl i_dut (.MCLK_I(mclk), .RESET_N_I(rst_n), .SYS_RESET_I(sys_rst),
        .USER_CFG_I(cfg), .RC_OSC_I(rc_osc), .WDOG_OSC_I(wd_osc),
        .EXT_CLK_PIN_I(ext_pin), .TRIM_WE_I(trim_we),
        .TRIM_WDATA_I(trim_wr_t'(wd[6:0])), .DIV_WE_I(div_we),
        .DIV_WDATA_I(wd), .CLOCK_LOW_POWER_BIT_WE_I(lp_we), .CLOCK_LOW_POWER_BIT_WDATA_I(wd[0]),
        .TRIM_O(trim), .RC_SEL_O(rc_sel), .DIV_O(div), .CLOCK_LOW_POWER_BIT_O(lp),
        .OSC_EN_O(osc_en), .CPU_EN_O(cpu_en), .PCLK_EN_O(pclk_en),
        .CPU_RUN_O(run), .ACTIVE_SRC_O(src), .PIN_GPIO_O(gpio));
    // Periods of 8, 10 and 6 system clocks, phases unrelated to it.
    ext_clk_src #(.HALF_NS(400), .OFS_NS(37)) i_rc (.en_i(osc_on),
        .idle_i(ext_idle), .clk_o(rc_osc));
    ext_clk_src #(.HALF_NS(500), .OFS_NS(13)) i_wd (.en_i(osc_on),
        .idle_i(ext_idle), .clk_o(wd_osc));
    ext_clk_src #(.HALF_NS(300), .OFS_NS(71)) i_ext (.en_i(ext_en),
        .idle_i(ext_idle), .clk_o(ext_pin));

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    function automatic logic [31:0] seen(input logic [3:0] s);
        case (s)
            4'h0: return {26'h0, trim};
            4'h1: return {31'h0, rc_sel};
            4'h2: return {24'h0, div};
            4'h3: return {31'h0, lp};
            4'h4: return {30'h0, src};
            4'h5: return cg;
            4'h6: return og;
            4'h7: return {31'h0, run};
            4'h9: return {31'h0, cpu_en};
            default: return {31'h0, gpio};
        endcase
    endfunction : seen

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %0h, wanted %0h", $time, got, exp);
        end
    endtask : check

    task automatic note(input logic [3:0] s, input logic [31:0] v);
        sel_q.push_back(s);
        val_q.push_back(v);
    endtask : note

    // Notes are compared at the next edge, before that edge's updates land.
    always @(posedge mclk) begin
        while (val_q.size() > 0) begin
            check(seen(sel_q.pop_front()), val_q.pop_front());
        end
    end

    always @(negedge mclk) begin
        cyc <= cyc + 1;
        if (cpu_en === 1'b1) begin
            cg <= cyc - lc;
            lc <= cyc;
        end
        if (osc_en === 1'b1) begin
            og <= cyc - lo;
            lo <= cyc;
        end
        if (run !== 1'b1) begin
            pk <= 0;
        end else if (pclk_en === 1'b1) begin
            check(pk + 1, 2);
            pk <= 0;
        end else if (cpu_en === 1'b1) begin
            pk <= pk + 1;
        end
    end

    // ----------------------------------------------------------------
    // Driving
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask : tick

    task automatic wr(input int w, input logic [7:0] v);
        trim_we = (w == 0);
        div_we = (w == 1);
        lp_we = (w == 2);
        wd = v;
        tick(1);
        {trim_we, div_we, lp_we} = 3'h0;
        tick(1);
    endtask : wr

    task automatic wait_hi(input logic [3:0] s, input int n);
        int k;
        k = 0;
        while (n > 0 && k < 20000) begin
            @(negedge mclk);
            k++;
            if (seen(s) === 32'h1) n--;
        end
        if (n > 0) check(32'h0, 32'h1);
        #60;
    endtask : wait_hi

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (90000) @(posedge mclk);
        err_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(92));
        tick(20);
        rst_n = 1'b1;
        note(4'h0, TRIM_FACTORY);
        note(4'h3, 32'h0);
        note(4'h4, SRC_RC);
        tick(1600);
        note(4'h7, 32'h0);
        wait_hi(4'h7, 1);
        $display("test reset and wake done");
        nl[4] = 8'($urandom_range(2, 9));
        foreach (nl[i]) begin
            wr(1, nl[i]);
            note(4'h2, nl[i]);
            wait_hi(4'h9, 4);
            note(4'h5, (nl[i] == 8'h00 ? 1 : 2 * nl[i]) * 8);
        end
        $display("test divider done");
        t = 6'($urandom_range(0, 63));
        wr(0, {2'h0, t});
        note(4'h0, t);
        // CPU clock far below the limit
        wr(2, 8'h01);
        note(4'h3, 32'h1);
        sys_rst = 1'b1;
        wr(1, 8'h03);
        sys_rst = 1'b0;
        note(4'h2, 32'h0);
        note(4'h3, 32'h0);
        note(4'h0, t);
        cfg.doubler = 1'b1;
        tick(5);
        wait_hi(4'h7, 1);
        wait_hi(4'h9, 3);
        note(4'h5, 32'h4);
        note(4'h6, 32'h4);
        cfg.doubler = 1'b0;
        $display("test soft reset and doubler done");
        wr(0, {2'h1, t});
        cfg.src = SRC_WDOG;
        wr(0, {2'h0, t});
        tick(5);
        wait_hi(4'h7, 1);
        note(4'h4, SRC_WDOG);
        wait_hi(4'h9, 3);
        note(4'h5, 32'hA);
        note(4'h6, 32'hA);
        wr(0, {2'h1, t});
        tick(5);
        wait_hi(4'h7, 1);
        note(4'h4, SRC_RC);
        note(4'h1, 32'h1);
        ext_idle = 1'b1;
        tick(6);
        note(4'h8, 32'h1);
        cfg.src = SRC_EXT;
        // rate stays low, no reset pin needed
        ext_en = 1'b1;
        wr(0, {2'h0, t});
        tick(5);
        wait_hi(4'h7, 1);
        note(4'h4, SRC_EXT);
        note(4'h8, 32'h0);
        wait_hi(4'h9, 3);
        note(4'h5, 32'h6);
        note(4'h6, 32'h6);
        tick(2);
        $display("test source switching done");
        wrap_up();
    end
endmodule : tb
